// ===== pts_pkg.sv
package pts_pkg;
    // ==================================================================
    // timing
    localparam int CLK_NS = 10;
    // charge window length in ns, rounded down to whole cycles
    localparam int CHARGE_NS = 200;
    localparam int CHARGE_CYC = (CHARGE_NS / CLK_NS) < 1 ? 1 :
        (CHARGE_NS / CLK_NS);
    // gap between end of charge and sampling, rounded up
    localparam int GAP_NS = 20;
    localparam int GAP_CYC = ((GAP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
        ((GAP_NS + CLK_NS - 1) / CLK_NS);
    // discharge time in ns, rounded up
    localparam int DISCH_NS = 500;
    localparam int DISCH_CYC = ((DISCH_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
        ((DISCH_NS + CLK_NS - 1) / CLK_NS);
    localparam int CNT_W = 8;
    // ==================================================================
    // reset values, adc channel count and sequencer states
    localparam logic [2:0] PWM_OFF = 3'h0;
    localparam logic CH_RST = 1'b0;
    localparam int ADC_CH = 4;
    typedef enum logic [2:0] {
        PTS_IDLE, PTS_CHARGE, PTS_GAP, PTS_CONVERT, PTS_DISCHARGE
    } pts_state_e;
endpackage

// ===== pts_sampler.sv
`timescale 1ns/1ns
// Function
// - comparator trip forces all pwm outputs off at once, without a clock
// - current input routed to comparator or adc; trip level is programmable
// - start trigger charges selected channel fixed time, then triggers adc
// - adc samples three back-voltage phases and slider channel together
// - slider channel alternates each pwm period
// - charge window starts from pwm-synchronous event, fits between edges
// - conversion starts a short gap after charging ends
// - after four conversions raise interrupt and start discharging capacitor in the same cycle
module pts_sampler
    import pts_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pwm stage
    input wire logic pwm_period_start,
    input wire logic [2:0] pwm_high_req,
    input wire logic [2:0] pwm_low_req,
    output logic [2:0] pwm_high,
    output logic [2:0] pwm_low,
    // overcurrent comparator and configuration
    input wire logic comp_trip,
    input wire logic current_to_adc,
    input wire logic [LEVEL_W-1:0] trip_level_cfg,
    input wire logic fault_clear,
    output logic [LEVEL_W-1:0] trip_level,
    output logic comp_enable,
    output logic adc_current_sel,
    output logic fault_latched,
    // charge time measure unit and adc
    output logic charge_en,
    output logic discharge_en,
    output logic slider_sel,
    output logic adc_sample,
    input wire logic adc_done,
    output logic adc_irq
);
    import pts_pkg::*;

    // ==================================================================
    // fault path
    logic fault_reg;
    logic [2:0] pwm_h_reg;
    logic [2:0] pwm_l_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault_reg <= 1'b0;
        end else if (comp_trip) begin
            fault_reg <= 1'b1;
        end else if (fault_clear) begin
            fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || comp_trip || fault_reg) begin
            pwm_h_reg <= PWM_OFF;
            pwm_l_reg <= PWM_OFF;
        end else begin
            pwm_h_reg <= pwm_high_req;
            pwm_l_reg <= pwm_low_req;
        end
    end

    // the trip gate bypasses the flops so shutdown needs no clock edge
    assign pwm_high = pwm_h_reg & {3{~comp_trip}};
    assign pwm_low = pwm_l_reg & {3{~comp_trip}};
    assign fault_latched = fault_reg;

    // ==================================================================
    // analog configuration
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trip_level <= '0;
            comp_enable <= 1'b0;
            adc_current_sel <= 1'b0;
        end else begin
            trip_level <= trip_level_cfg;
            comp_enable <= ~current_to_adc;
            adc_current_sel <= current_to_adc;
        end
    end

    // ==================================================================
    // measurement sequencer
    pts_state_e state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [2:0] done_cnt_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= PTS_IDLE;
            cnt_reg <= '0;
            done_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                PTS_IDLE: begin
                    // period start sits far from switching edges
                    if (pwm_period_start) begin
                        state_reg <= PTS_CHARGE;
                        cnt_reg <= CNT_W'(CHARGE_CYC - 1);
                    end
                end
                PTS_CHARGE: begin
                    if (cnt_reg == '0) begin
                        state_reg <= PTS_GAP;
                        cnt_reg <= CNT_W'(GAP_CYC - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                PTS_GAP: begin
                    if (cnt_reg == '0) begin
                        state_reg <= PTS_CONVERT;
                        done_cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                PTS_CONVERT: begin
                    if (adc_done) begin
                        if (done_cnt_reg == 3'(ADC_CH - 1)) begin
                            state_reg <= PTS_DISCHARGE;
                            cnt_reg <= CNT_W'(DISCH_CYC - 1);
                        end else begin
                            done_cnt_reg <= done_cnt_reg + 1'b1;
                        end
                    end
                end
                PTS_DISCHARGE: begin
                    if (cnt_reg == '0) begin
                        state_reg <= PTS_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    // outputs registered from next-state terms
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            charge_en <= 1'b0;
            discharge_en <= 1'b0;
            adc_sample <= 1'b0;
            adc_irq <= 1'b0;
        end else begin
            charge_en <= (state_reg == PTS_IDLE && pwm_period_start) ||
                (state_reg == PTS_CHARGE && cnt_reg != '0);
            // one pulse samples all four channels at once
            adc_sample <= state_reg == PTS_GAP && cnt_reg == '0;
            adc_irq <= state_reg == PTS_CONVERT && adc_done &&
                done_cnt_reg == 3'(ADC_CH - 1);
            discharge_en <= (state_reg == PTS_CONVERT && adc_done &&
                done_cnt_reg == 3'(ADC_CH - 1)) ||
                (state_reg == PTS_DISCHARGE && cnt_reg != '0);
        end
    end

    // channel flips at the end of each discharge, i.e. once per period
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slider_sel <= CH_RST;
        end else if (state_reg == PTS_DISCHARGE && cnt_reg == '0) begin
            slider_sel <= ~slider_sel;
        end
    end

    // ==================================================================
    // checks
    // the charge window is counted here, so its length is checked on a
    // small counter instead of a long run of repeated cycles
    logic [CNT_W-1:0] chg_run_reg;

    always_ff @(posedge sys_clk) begin
        if (rst || !charge_en) begin
            chg_run_reg <= '0;
        end else begin
            chg_run_reg <= chg_run_reg + 1'b1;
        end
    end

    trip_forces_off_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        comp_trip |-> (pwm_high == 3'h0 && pwm_low == 3'h0))
        else $error("pwm active during trip");
    fault_holds_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        fault_reg && !fault_clear |=> fault_reg && pwm_high == 3'h0)
        else $error("fault released without clear");
    route_cfg_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        current_to_adc |=> adc_current_sel && !comp_enable)
        else $error("current routing wrong");
    charge_len_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(charge_en) |-> chg_run_reg == CNT_W'(CHARGE_CYC))
        else $error("charge window length wrong");
    charge_cap_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        charge_en |-> chg_run_reg < CNT_W'(CHARGE_CYC))
        else $error("charge window overran");
    gap_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(charge_en) |-> !adc_sample ##2 adc_sample)
        else $error("sample not after gap");
    start_sync_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(charge_en) |-> $past(pwm_period_start))
        else $error("charge not period synced");
    sample_once_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        adc_sample |=> !adc_sample)
        else $error("sample pulse too long");
    irq_disch_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        adc_irq |-> discharge_en ##1 !adc_irq)
        else $error("irq without discharge");
    alternate_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (charge_en || adc_sample || adc_irq) |-> $stable(slider_sel))
        else $error("channel changed mid measurement");
    channel_flip_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(discharge_en) |-> slider_sel != $past(slider_sel))
        else $error("channel did not alternate");
endmodule

// ===== pts_adc_model.sv
`timescale 1ns/1ns
module pts_adc_model (
    // clock and sample strobe
    input wire logic sys_clk,
    input wire logic adc_sample,
    input wire logic [1:0] conv_gap,
    // per-channel completion
    output logic adc_done
);
    // ==============================================
    // converter
    initial adc_done = 1'b0;
    // all four channels are held at once, then finish one by one
    always @(posedge sys_clk) begin
        if (adc_sample) begin
            repeat (4) begin
                repeat (conv_gap) @(posedge sys_clk);
                #1 adc_done = 1'b1;
                @(posedge sys_clk);
                #1 adc_done = 1'b0;
            end
        end
    end
endmodule

// ===== test_pwm_synced_touch_phase_back_voltage_sense_sampler.sv
`timescale 1ns/1ns
module test_pwm_synced_touch_phase_back_voltage_sense_sampler;
    import pts_pkg::*;
    logic sys_clk = 0, rst = 1, pwm_period_start = 0, comp_trip = 0;
    logic current_to_adc = 0, fault_clear = 0, adc_done, sel_exp = 0;
    logic [2:0] pwm_high_req = 3'h0, pwm_low_req = 3'h0, pwm_high, pwm_low;
    logic [7:0] trip_level_cfg = 8'h00, trip_level;
    logic comp_enable, adc_current_sel, fault_latched, charge_en;
    logic discharge_en, slider_sel, adc_sample, adc_irq;
    logic [1:0] conv_gap = 2'h1;
    logic [9:0] q[$];
    int num_errors = 0, comparisons = 0, cc = 0, i;
    always #5 sys_clk = ~sys_clk;
    pts_sampler uut (.sys_clk(sys_clk), .rst(rst),
        .pwm_period_start(pwm_period_start), .pwm_high_req(pwm_high_req),
        .pwm_low_req(pwm_low_req), .pwm_high(pwm_high), .pwm_low(pwm_low),
        .comp_trip(comp_trip), .current_to_adc(current_to_adc),
        .trip_level_cfg(trip_level_cfg), .fault_clear(fault_clear),
        .trip_level(trip_level), .comp_enable(comp_enable),
        .adc_current_sel(adc_current_sel), .fault_latched(fault_latched),
        .charge_en(charge_en), .discharge_en(discharge_en),
        .slider_sel(slider_sel), .adc_sample(adc_sample),
        .adc_done(adc_done), .adc_irq(adc_irq));
    pts_adc_model adc (.sys_clk(sys_clk), .adc_sample(adc_sample),
        .conv_gap(conv_gap), .adc_done(adc_done));
    task check(string n, logic [9:0] e, logic [9:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %0h seen %0h", n, e, g);
            num_errors++;
        end
    endtask
    task conclude();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==============================================
    // watcher: charge length, discharge and channel at each interrupt
    always @(posedge sys_clk) begin
        if (pwm_period_start) cc <= 0;
        else if (charge_en === 1'b1) cc <= cc + 1;
        if (adc_sample === 1'b1)
            check("charge_at_sample", 0, charge_en);
        if (adc_irq === 1'b1) check("irq_cycle", q.pop_front(),
            {discharge_en, slider_sel, cc[7:0]});
    end
    task run_cycle();
        q.push_back({1'b1, sel_exp, 8'(CHARGE_CYC)});
        conv_gap = 2'(1 + $urandom % 3);
        pwm_period_start = 1;
        @(posedge sys_clk) #1 pwm_period_start = 0;
        i = 0;
        while (discharge_en !== 1'b1 && i < 400) begin
            @(posedge sys_clk) #1 i++;
        end
        while (discharge_en !== 1'b0 && i < 400) begin
            @(posedge sys_clk) #1 i++;
        end
        check("cycle_end", 0, (i >= 400) | q.size());
        sel_exp = ~sel_exp;
        $display("test cycle done");
    endtask
    initial begin
        void'($urandom(32'h5292));
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        repeat (3) run_cycle();
        for (int k = 0; k < 2; k++) begin
            current_to_adc = k[0];
            trip_level_cfg = 8'($urandom);
            repeat (2) @(posedge sys_clk);
            #1 check("cfg", {~k[0], k[0], trip_level_cfg},
                {comp_enable, adc_current_sel, trip_level});
        end
        $display("test config done");
        pwm_high_req = 3'($urandom);
        pwm_low_req = ~pwm_high_req;
        repeat (2) @(posedge sys_clk);
        #1 check("pwm_on", {pwm_high_req, pwm_low_req},
            {pwm_high, pwm_low});
        check("fault_idle", 0, fault_latched);
        #2 comp_trip = 1;
        #1 check("pwm_trip", 0, {pwm_high, pwm_low});
        @(posedge sys_clk) #1 comp_trip = 0;
        repeat (2) @(posedge sys_clk);
        #1 check("pwm_held", 0, {pwm_high, pwm_low});
        check("fault_set", 1, fault_latched);
        fault_clear = 1;
        @(posedge sys_clk) #1 fault_clear = 0;
        repeat (2) @(posedge sys_clk);
        #1 check("pwm_back", {pwm_high_req, pwm_low_req},
            {pwm_high, pwm_low});
        check("fault_clr", 0, fault_latched);
        $display("test fault done");
        conclude();
    end
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
endmodule
